// ===== verilog/emc_ctrl.sv
// nonvolatile control, load/commit/program sequencer and memory data port addressing
`timescale 1ns/1ns
`include "emc_cfg.svh"
module emc_ctrl
  import emc_pkg::*;
#(
  parameter int NV_BYTES = `EMC_NV_BYTES,
  parameter int PAGE_W = 2,
  parameter int PROG_CYCLES = `EMC_PROG_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr, // register offset from the serial slave
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd, // read strobe
  output logic reg_rd_ready, // low while reads are refused
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid, // read answer strobe
  input wire logic txn_end, // end of a serial transaction
  input wire logic unlock_armed, // previous transaction wrote the key
  input wire logic keep_aux_clock_after_lock, // aux clock running, async level
  input wire logic [7:0] mem_addr_low, // low address byte, neighbour register
  input wire logic [PAGE_W-1:0] sram_dest_page_select,
  output logic [8:0] cfg_idx, // live register index
  output logic cfg_we,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata, // valid one cycle after cfg_idx
  output logic [8:0] nv_addr,
  output logic nv_rd,
  input wire logic [7:0] nv_rdata, // one cycle read latency
  output logic nv_we,
  output logic [7:0] nv_wdata,
  output logic [8:0] sram_addr,
  output logic sram_rd,
  output logic sram_we,
  output logic [7:0] sram_wdata,
  input wire logic [7:0] sram_rdata, // one cycle read latency
  output logic [11:0] rom_addr,
  input wire logic [7:0] rom_rdata, // one cycle read latency
  output logic [7:0] write_cycle_counter,
  output logic nv_write_in_progress,
  output logic loading
);
  localparam logic [8:0] LAST_IDX = 9'(NV_BYTES - 1);
  localparam logic [8:0] CRC_IDX = 9'(NV_BYTES - 1); // checksum byte is last
  localparam logic [8:0] CNT_IDX = 9'(NV_BYTES - 2); // counter byte before it

  // data port offsets share the address auto-advance
  function automatic logic is_data_port(input logic [7:0] a);
    return (a == `EMC_OFS_NVDAT) || (a == `EMC_OFS_SRAM_DATA_PORT) || (a == `EMC_OFS_ROMDAT);
  endfunction

  emc_state_e st_q, st_d; // sequencer state
  logic [8:0] idx_q, idx_d; // byte index of the running sequence
  logic [7:0] crc_q, crc_d; // running checksum
  logic [7:0] lcrc_q, lcrc_d; // live checksum register
  logic commit_q, commit_d; // copy trigger
  logic ld_q, ld_d; // load trigger
  logic boot_q, boot_d; // load owed after reset
  logic prog_q, prog_d; // program trigger
  logic auto_q, auto_d; // auto checksum enable
  logic fault_q, fault_d; // checksum fault flag
  logic [3:0] adrh_q, adrh_d; // address bits 11:8
  logic [11:0] ptr_q, ptr_d; // data port pointer
  logic [7:0] cnt_q, cnt_d; // write cycle counter
  logic rd_pend_q, rd_ok_q; // read accepted last cycle, memory was free for it
  logic [7:0] rd_addr_q; // offset of that read
  logic [7:0] rdata_q, rdata_d; // read answer register
  logic rd_valid_q; // read answer strobe register
  logic aux_s1_q, aux_s2_q; // aux clock synchroniser, first and second stage
  logic [7:0] crc_in_data, crc_next; // checksum step input and result
  logic [7:0] pg_byte, cnt_inc; // program byte, saturating counter plus one
  logic accept, eng_idle, quiet; // read taken, sequencer idle, no host access in flight
  logic tmr_start, tmr_done; // cycle timer handshake

  emc_crc8 #(.POLY(`EMC_CRC_POLY)) u_crc
  (
    .crc_in(crc_q),
    .data_in(crc_in_data),
    .crc_out(crc_next)
  );

  emc_timer #(.CYCLES(PROG_CYCLES)) u_tmr
  (
    .mclk(mclk),
    .rst(rst),
    .start(tmr_start),
    .done(tmr_done)
  );

  // helper terms; busy and loading are plain decodes of the state
  always_comb
  begin
    eng_idle = (st_q == EMC_IDLE);
    loading = (st_q == EMC_LD_ADDR) || (st_q == EMC_LD_DATA);
    nv_write_in_progress = (st_q == EMC_PG_ADDR) || (st_q == EMC_PG_DATA)
      || (st_q == EMC_PG_WAIT);
    reg_rd_ready = !loading;
    accept = reg_rd && !loading;
    quiet = !reg_rd && !reg_wr && !rd_pend_q;
    cnt_inc = (cnt_q == `EMC_CNT_MAX) ? cnt_q : cnt_q + 8'h1;
    // computed checksum replaces the last byte only when enabled
    if (idx_q == CRC_IDX && auto_q)
      pg_byte = crc_q;
    else if (idx_q == CNT_IDX)
      pg_byte = cnt_inc;
    else
      pg_byte = sram_rdata;
    crc_in_data = loading ? nv_rdata : pg_byte;
    tmr_start = (st_q == EMC_PG_DATA) && (idx_q == LAST_IDX);
  end

  // memory port steering; the sequencer owns the arrays while it runs
  always_comb
  begin
    cfg_idx = idx_q;
    cfg_we = (st_q == EMC_LD_DATA);
    cfg_wdata = nv_rdata;
    nv_rd = (st_q == EMC_LD_ADDR)
      || (accept && reg_addr == `EMC_OFS_NVDAT && eng_idle);
    nv_addr = eng_idle ? ptr_q[8:0] : idx_q;
    nv_we = (st_q == EMC_PG_DATA);
    nv_wdata = pg_byte;
    sram_rd = (st_q == EMC_PG_ADDR)
      || (accept && reg_addr == `EMC_OFS_SRAM_DATA_PORT && eng_idle);
    sram_we = (st_q == EMC_CM_DATA)
      || (reg_wr && reg_addr == `EMC_OFS_SRAM_DATA_PORT && eng_idle);
    if (st_q == EMC_CM_DATA)
      sram_addr = 9'(int'(sram_dest_page_select) * NV_BYTES) + idx_q;
    else if (!eng_idle)
      sram_addr = idx_q;
    else
      sram_addr = ptr_q[8:0];
    sram_wdata = (st_q == EMC_CM_DATA) ? cfg_rdata : reg_wdata;
    rom_addr = ptr_q;
    write_cycle_counter = cnt_q;
  end

  // sequencer and register next values; host writes come last so a set wins
  always_comb
  begin
    st_d = st_q;
    idx_d = idx_q;
    crc_d = crc_q;
    lcrc_d = lcrc_q;
    commit_d = commit_q;
    ld_d = ld_q;
    boot_d = boot_q;
    prog_d = prog_q;
    auto_d = auto_q;
    fault_d = fault_q;
    adrh_d = adrh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    unique case (st_q)
      EMC_IDLE:
      begin
        // load first, then program, then copy; wait for a quiet host cycle
        if (quiet && (ld_q || boot_q) && aux_s2_q)
        begin
          st_d = EMC_LD_ADDR;
          idx_d = 9'h0;
          crc_d = 8'h00;
        end
        else if (quiet && prog_q)
        begin
          st_d = EMC_PG_ADDR;
          idx_d = 9'h0;
          crc_d = 8'h00;
        end
        else if (quiet && commit_q)
        begin
          st_d = EMC_CM_ADDR;
          idx_d = 9'h0;
        end
      end
      EMC_LD_ADDR:
        st_d = EMC_LD_DATA;
      EMC_LD_DATA:
      begin
        if (idx_q == CNT_IDX)
          cnt_d = nv_rdata; // counter retrieved with the load
        if (idx_q == CRC_IDX)
          fault_d = (crc_q != nv_rdata);
        else
          crc_d = crc_next;
        if (idx_q == LAST_IDX)
        begin
          st_d = EMC_IDLE;
          ld_d = 1'b0;
          boot_d = 1'b0;
          lcrc_d = crc_q;
        end
        else
        begin
          st_d = EMC_LD_ADDR;
          idx_d = idx_q + 9'h1;
        end
      end
      EMC_CM_ADDR:
        st_d = EMC_CM_DATA;
      EMC_CM_DATA:
      begin
        if (idx_q == LAST_IDX)
        begin
          st_d = EMC_IDLE;
          commit_d = 1'b0;
        end
        else
        begin
          st_d = EMC_CM_ADDR;
          idx_d = idx_q + 9'h1;
        end
      end
      EMC_PG_ADDR:
        st_d = EMC_PG_DATA;
      EMC_PG_DATA:
      begin
        if (idx_q != CRC_IDX)
          crc_d = crc_next;
        if (idx_q == LAST_IDX)
          st_d = EMC_PG_WAIT; // timer starts here
        else
        begin
          st_d = EMC_PG_ADDR;
          idx_d = idx_q + 9'h1;
        end
      end
      EMC_PG_WAIT:
      begin
        // the array stays busy until the cycle time is out
        if (tmr_done)
        begin
          st_d = EMC_IDLE;
          prog_d = 1'b0;
          cnt_d = cnt_inc;
        end
      end
    endcase
    // pointer reloads between transactions, advances on data port use
    if (txn_end)
      ptr_d = {adrh_q, mem_addr_low};
    if ((accept || reg_wr) && is_data_port(reg_addr))
      ptr_d = ptr_q + 12'h1;
    if (reg_wr && reg_addr == `EMC_OFS_CTL)
    begin
      auto_d = reg_wdata[`EMC_BIT_AUTOCRC];
      if (reg_wdata[`EMC_BIT_COMMIT])
        commit_d = 1'b1;
      if (reg_wdata[`EMC_BIT_LOAD])
        ld_d = 1'b1;
      // without the key the start is dropped, so the bit reads back zero
      if (reg_wdata[`EMC_BIT_PROG] && unlock_armed)
        prog_d = 1'b1;
    end
    if (reg_wr && reg_addr == `EMC_OFS_ADRH)
    begin
      adrh_d = reg_wdata[3:0];
      ptr_d = {reg_wdata[3:0], mem_addr_low};
    end
  end

  // read answer: offset latched at accept, data captured a cycle later
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (rd_addr_q)
      `EMC_OFS_CTL:
        rdata_d = {1'b0, commit_q, fault_q, auto_q, ld_q || boot_q,
          nv_write_in_progress, 1'b0, prog_q};
      `EMC_OFS_LCRC:
        rdata_d = lcrc_q;
      `EMC_OFS_ADRH:
        rdata_d = {4'h0, adrh_q};
      `EMC_OFS_NVDAT:
        rdata_d = rd_ok_q ? nv_rdata : 8'h00;
      `EMC_OFS_SRAM_DATA_PORT:
        rdata_d = rd_ok_q ? sram_rdata : 8'h00;
      `EMC_OFS_ROMDAT:
        rdata_d = rom_rdata;
      default:
        rdata_d = 8'h00; // offsets outside this block read zero
    endcase
    if (!rd_pend_q)
      rdata_d = rdata_q; // hold the last answer
    reg_rdata = rdata_q;
    reg_rd_valid = rd_valid_q;
  end

  // state registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= EMC_IDLE;
      idx_q <= 9'h0;
      crc_q <= 8'h00;
      lcrc_q <= `EMC_LCRC_RST;
      commit_q <= 1'b0;
      ld_q <= 1'b0;
      boot_q <= 1'b1;
      prog_q <= 1'b0;
      auto_q <= `EMC_AUTOCRC_RST;
      fault_q <= 1'b0;
      adrh_q <= `EMC_ADRH_RST;
      ptr_q <= 12'h000;
      cnt_q <= `EMC_CNT_RST;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      rd_ok_q <= 1'b0;
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
      aux_s1_q <= 1'b0;
      aux_s2_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      idx_q <= idx_d;
      crc_q <= crc_d;
      lcrc_q <= lcrc_d;
      commit_q <= commit_d;
      ld_q <= ld_d;
      boot_q <= boot_d;
      prog_q <= prog_d;
      auto_q <= auto_d;
      fault_q <= fault_d;
      adrh_q <= adrh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      rd_pend_q <= accept;
      rd_addr_q <= accept ? reg_addr : rd_addr_q;
      rd_ok_q <= eng_idle;
      rdata_q <= rdata_d;
      rd_valid_q <= rd_pend_q;
      aux_s1_q <= keep_aux_clock_after_lock;
      aux_s2_q <= aux_s1_q;
    end
  end
endmodule

// ===== verilog/emc_cfg.svh
// offsets, field positions, reset values and timing counts of the nonvolatile control block
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH
// register offsets on the serial register map
`define EMC_OFS_CTL 8'h89
`define EMC_OFS_LCRC 8'h8a
`define EMC_OFS_ADRH 8'h8b
`define EMC_OFS_NVDAT 8'h8d
`define EMC_OFS_SRAM_DATA_PORT 8'h8e
`define EMC_OFS_ROMDAT 8'h8f
// control register field positions
`define EMC_BIT_COMMIT 6
`define EMC_BIT_CRCERR 5
`define EMC_BIT_AUTOCRC 4
`define EMC_BIT_LOAD 3
`define EMC_BIT_BUSY 2
`define EMC_BIT_PROG 0
// reset values, counter saturation limit
`define EMC_AUTOCRC_RST 1'b1
`define EMC_ADRH_RST 4'h0
`define EMC_LCRC_RST 8'h00
`define EMC_CNT_RST 8'h00
`define EMC_CNT_MAX 8'hff
// array size, checksum polynomial
`define EMC_NV_BYTES 128
`define EMC_CRC_POLY 8'h07
// erase/program time and clock rate
`define EMC_PROG_TIME_MS 230
`define EMC_CLK_KHZ 250000
`define EMC_PROG_CYCLES (`EMC_PROG_TIME_MS * `EMC_CLK_KHZ)
`endif

// ===== verilog/emc_pkg.sv
// types shared by the nonvolatile control block
package emc_pkg;
  // sequencer states
  typedef enum logic [2:0]
  {
    EMC_IDLE = 3'b000,
    EMC_LD_ADDR = 3'b001,
    EMC_LD_DATA = 3'b010,
    EMC_CM_ADDR = 3'b011,
    EMC_CM_DATA = 3'b100,
    EMC_PG_ADDR = 3'b101,
    EMC_PG_DATA = 3'b110,
    EMC_PG_WAIT = 3'b111
  } emc_state_e;
  typedef logic [7:0] emc_byte_t;
endpackage

// ===== verilog/emc_crc8.sv
// one byte step of the configuration checksum
`timescale 1ns/1ns
`include "emc_cfg.svh"
module emc_crc8
  import emc_pkg::*;
#(
  parameter logic [7:0] POLY = `EMC_CRC_POLY
)
(
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  // msb-first shift, one bit per loop pass
  always_comb
  begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
    end
    crc_out = c;
  end
endmodule

// ===== verilog/emc_timer.sv
// one-shot down counter timing the erase/program cycle
`timescale 1ns/1ns
`include "emc_cfg.svh"
module emc_timer
  import emc_pkg::*;
#(
  parameter int CYCLES = `EMC_PROG_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  logic [31:0] cnt_q; // cycles left
  logic [31:0] cnt_d;
  logic run_q; // counting
  logic run_d;
  // next count; start restarts, last cycle pulses done
  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    done = 1'b0;
    if (start)
    begin
      cnt_d = 32'(CYCLES - 1);
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q == 32'h0)
      begin
        run_d = 1'b0;
        done = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - 32'h1;
      end
    end
  end
  // registers only
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule

// ===== testbench/emc_ctrl_sva.sv
// concurrent checks on the nonvolatile control block ports
`timescale 1ns/1ns
module emc_ctrl_sva
#(
  parameter int NV_BYTES = 8,
  parameter int PAGE_W = 2,
  parameter int PROG_CYCLES = 20
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rd_ready,
  input wire logic reg_rd_valid,
  input wire logic unlock_armed,
  input wire logic [PAGE_W-1:0] sram_dest_page_select,
  input wire logic [8:0] cfg_idx,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic [8:0] nv_addr,
  input wire logic nv_rd,
  input wire logic [7:0] nv_rdata,
  input wire logic nv_we,
  input wire logic [8:0] sram_addr,
  input wire logic sram_we,
  input wire logic [7:0] sram_wdata,
  input wire logic [7:0] write_cycle_counter,
  input wire logic nv_write_in_progress,
  input wire logic loading
);
  logic [31:0] busy_cnt_q; // cycles spent busy so far
  logic [31:0] busy_cnt_d;
  // busy length counter, cleared whenever busy drops
  always_comb
  begin
    busy_cnt_d = nv_write_in_progress ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_lat;
    reg_rd && reg_rd_ready |-> ##2 reg_rd_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
  property p_ld_quiet;
    loading |-> !reg_rd_ready && !reg_rd_valid;
  endproperty
  a_ld_quiet: assert property (p_ld_quiet) else $error("read served in load");
  property p_ld_we;
    cfg_we |-> loading && cfg_wdata == nv_rdata && cfg_idx == $past(nv_addr);
  endproperty
  a_ld_we: assert property (p_ld_we) else $error("load byte wrong");
  // a host data-port write raises the same strobe in its own cycle, so it is left out
  property p_cm_we;
    sram_we && !reg_wr |-> sram_wdata == cfg_rdata &&
      sram_addr == 9'(sram_dest_page_select * NV_BYTES) + $past(cfg_idx);
  endproperty
  a_cm_we: assert property (p_cm_we) else $error("copy byte wrong");
  property p_busy_nv;
    nv_write_in_progress |-> !nv_rd && !loading;
  endproperty
  a_busy_nv: assert property (p_busy_nv) else $error("array used while busy");
  property p_nv_we;
    nv_we |-> nv_write_in_progress;
  endproperty
  a_nv_we: assert property (p_nv_we) else $error("array written while idle");
  property p_key;
    $rose(nv_write_in_progress) |-> $past(unlock_armed);
  endproperty
  a_key: assert property (p_key) else $error("program without key");
  property p_busy_len;
    $fell(nv_write_in_progress) |-> busy_cnt_q >= PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("program cycle short");
  property p_busy_max;
    busy_cnt_q <= PROG_CYCLES + 2 * NV_BYTES + 8;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy stuck");
  property p_cnt_sat;
    !loading && $past(write_cycle_counter) == 8'hff |-> write_cycle_counter == 8'hff;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");
endmodule

// ===== testbench/emc_mem_model.sv
// far-side memories: live registers, nonvolatile array, sram and rom
`timescale 1ns/1ns
module emc_mem_model
(
  input wire logic mclk,
  input wire logic [8:0] cfg_idx,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [8:0] nv_addr,
  input wire logic nv_rd,
  output logic [7:0] nv_rdata,
  input wire logic nv_we,
  input wire logic [7:0] nv_wdata,
  input wire logic [8:0] sram_addr,
  input wire logic sram_rd,
  input wire logic sram_we,
  input wire logic [7:0] sram_wdata,
  output logic [7:0] sram_rdata,
  input wire logic [11:0] rom_addr,
  output logic [7:0] rom_rdata
);
  logic [7:0] cfg [512]; // live configuration registers
  logic [7:0] nv [512]; // nonvolatile array, preloaded by the bench
  logic [7:0] sram [512]; // staging pages
  initial
  begin
    nv_rdata = 8'h00;
    sram_rdata = 8'h00;
  end
  // one-cycle reads; an idle port flips its data so a stale byte never passes
  always @(posedge mclk)
  begin
    cfg_rdata <= cfg[cfg_idx];
    nv_rdata <= nv_rd ? nv[nv_addr] : ~nv_rdata;
    sram_rdata <= sram_rd ? sram[sram_addr] : ~sram_rdata;
    rom_rdata <= rom_addr[7:0] ^ {rom_addr[11:8], 4'h5};
    if (cfg_we)
      cfg[cfg_idx] <= cfg_wdata;
    if (nv_we)
      nv[nv_addr] <= nv_wdata;
    if (sram_we)
      sram[sram_addr] <= sram_wdata;
  end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the nonvolatile control block
`timescale 1ns/1ns
`include "emc_cfg.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module tb;
  import emc_pkg::*;
  localparam int NB = 8; // shortened array so loads stay brief
  logic mclk, rst, reg_wr, reg_rd, txn_end, unlock_armed, aux, reg_rd_ready, reg_rd_valid;
  logic cfg_we, nv_rd, nv_we, sram_rd, sram_we, nv_write_in_progress, loading;
  logic [7:0] reg_addr, reg_wdata, mem_addr_low, v, reg_rdata, cfg_wdata, cfg_rdata;
  logic [7:0] nv_rdata, nv_wdata, sram_wdata, sram_rdata, rom_rdata, write_cycle_counter;
  logic [1:0] page;
  logic [8:0] cfg_idx, nv_addr, sram_addr;
  logic [11:0] rom_addr;
  int fails = 0;
  int checks = 0;
  emc_ctrl #(.NV_BYTES(NB), .PAGE_W(2), .PROG_CYCLES(20)) dut_u (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rd_ready(reg_rd_ready), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .txn_end(txn_end), .unlock_armed(unlock_armed), .keep_aux_clock_after_lock(aux),
    .mem_addr_low(mem_addr_low), .sram_dest_page_select(page), .cfg_idx(cfg_idx),
    .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .nv_addr(nv_addr),
    .nv_rd(nv_rd), .nv_rdata(nv_rdata), .nv_we(nv_we), .nv_wdata(nv_wdata),
    .sram_addr(sram_addr), .sram_rd(sram_rd), .sram_we(sram_we), .sram_wdata(sram_wdata),
    .sram_rdata(sram_rdata), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
    .write_cycle_counter(write_cycle_counter), .nv_write_in_progress(nv_write_in_progress),
    .loading(loading));
  emc_mem_model mem_u (.mclk(mclk), .cfg_idx(cfg_idx), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_rdata(nv_rdata),
    .nv_we(nv_we), .nv_wdata(nv_wdata), .sram_addr(sram_addr), .sram_rd(sram_rd),
    .sram_we(sram_we), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata),
    .rom_addr(rom_addr), .rom_rdata(rom_rdata));
  // checksum over all stored bytes but the last
  function automatic logic [7:0] crc7();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < NB - 1; i++)
    begin
      c = c ^ mem_u.nv[i];
      for (int b = 0; b < 8; b++)
        c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // writes and reads start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    while (reg_rd_ready !== 1'b1 && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rd_valid !== 1'b1 && n < 5)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    d = reg_rdata;
    @(negedge mclk);
  endtask
  // poll control until the masked bits read zero
  task automatic poll(input logic [7:0] m);
    for (int n = 0; n < 300; n++)
    begin
      // a quiet cycle between polls lets a pending sequence start
      @(negedge mclk);
      rd(`EMC_OFS_CTL, v);
      if ((v & m) === 8'h00)
        break;
    end
  endtask
  task automatic t_boot;
    poll(8'h08);
    `CHK(v, 8'h10)
    rd(`EMC_OFS_LCRC, v);
    `CHK(v, crc7())
    rd(`EMC_OFS_ADRH, v);
    `CHK(v, 8'h00)
    for (int i = 0; i < NB; i++)
      `CHK(mem_u.cfg[i], mem_u.nv[i])
    `CHK(write_cycle_counter, 8'hfe)
  endtask
  // load held off while the aux clock is stopped, then a checksum fault
  task automatic t_fault;
    mem_u.nv[NB-1] = ~crc7();
    aux = 1'b0;
    repeat (4) @(negedge mclk);
    wr(`EMC_OFS_CTL, 8'h18);
    repeat (10) @(negedge mclk);
    `CHK(loading, 1'b0)
    aux = 1'b1;
    poll(8'h08);
    `CHK(v, 8'h30)
    mem_u.nv[NB-1] = crc7();
    wr(`EMC_OFS_CTL, 8'h18);
    poll(8'h08);
    `CHK(v, 8'h10)
  endtask
  task automatic t_copy;
    wr(`EMC_OFS_CTL, 8'h50);
    poll(8'h40);
    `CHK(v, 8'h10)
    for (int i = 0; i < NB; i++)
      `CHK(mem_u.sram[2*NB+i], mem_u.cfg[i])
  endtask
  // refused start without key, then two programs, the second without auto checksum
  task automatic t_prog;
    wr(`EMC_OFS_CTL, 8'h11);
    rd(`EMC_OFS_CTL, v);
    `CHK(v, 8'h10)
    unlock_armed = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(`EMC_OFS_CTL, k ? 8'h01 : 8'h11);
      rd(`EMC_OFS_CTL, v);
      `CHK(v[2], 1'b1)
      poll(8'h05);
      `CHK(v, k ? 8'h00 : 8'h10)
      for (int i = 0; i < NB - 2; i++)
        `CHK(mem_u.nv[i], mem_u.sram[i])
      `CHK(mem_u.nv[NB-2], 8'hff)
      `CHK(mem_u.nv[NB-1], k ? mem_u.sram[NB-1] : crc7())
      `CHK(write_cycle_counter, 8'hff)
    end
    unlock_armed = 1'b0;
  endtask
  task automatic t_rom;
    wr(`EMC_OFS_ADRH, 8'hf3);
    rd(`EMC_OFS_ADRH, v);
    `CHK(v, 8'h03)
    mem_addr_low = 8'h21;
    txn_end = 1'b1;
    @(negedge mclk);
    txn_end = 1'b0;
    rd(`EMC_OFS_ROMDAT, v);
    `CHK(v, 8'h14)
    rd(`EMC_OFS_ROMDAT, v);
    `CHK(v, 8'h17)
    // sram write then nonvolatile read share the pointer, then reload and read back
    wr(`EMC_OFS_ADRH, 8'h00);
    wr(`EMC_OFS_SRAM_DATA_PORT, 8'h5c);
    rd(`EMC_OFS_NVDAT, v);
    `CHK(v, 8'h32)
    txn_end = 1'b1;
    @(negedge mclk);
    txn_end = 1'b0;
    rd(`EMC_OFS_SRAM_DATA_PORT, v);
    `CHK(v, 8'h5c)
  endtask
  task automatic finish_test;
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (30000) @(posedge mclk);
    fails++;
    finish_test();
  end
  initial
  begin
    {reg_wr, reg_rd, txn_end, unlock_armed} = 4'h0;
    {reg_addr, reg_wdata, mem_addr_low} = 24'h0;
    aux = 1'b1;
    page = 2'h2;
    rst = 1'b1;
    for (int i = 0; i < 512; i++)
    begin
      mem_u.nv[i] = 8'(i + 16);
      mem_u.sram[i] = 8'(i) ^ 8'ha5;
    end
    mem_u.nv[NB-2] = 8'hfe;
    mem_u.nv[NB-1] = crc7();
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_boot();
    t_fault();
    t_copy();
    t_prog();
    t_rom();
    finish_test();
  end
endmodule
bind emc_ctrl emc_ctrl_sva #(.NV_BYTES(NV_BYTES), .PAGE_W(PAGE_W), .PROG_CYCLES(PROG_CYCLES))
  chk_u (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_ready(reg_rd_ready),
  .reg_rd_valid(reg_rd_valid), .unlock_armed(unlock_armed),
  .sram_dest_page_select(sram_dest_page_select), .cfg_idx(cfg_idx), .cfg_we(cfg_we),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .nv_addr(nv_addr), .nv_rd(nv_rd),
  .nv_rdata(nv_rdata), .nv_we(nv_we), .sram_addr(sram_addr), .sram_we(sram_we),
  .sram_wdata(sram_wdata), .write_cycle_counter(write_cycle_counter),
  .nv_write_in_progress(nv_write_in_progress), .loading(loading));
